// ### src/pec_classifier.sv
`timescale 1ns/100ps
module pec_classifier import pec_pkg::*; #(
  parameter int REPLAY_LIMIT = REPLAY_CYCLES,
  parameter int CPL_LIMIT    = CPL_CYCLES,
  parameter int ROLL_MAX     = ROLLOVER_MAX
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Fatal sources
  input  wire logic                   training_err,
  input  wire logic                   dll_proto_err,
  input  wire logic                   fc_proto_err,
  input  wire logic                   malformed_tlp,
  input  wire logic                   rx_overflow,
  // Receive link errors
  input  wire logic                   receiver_err,
  input  wire logic                   bad_tlp,
  input  wire logic                   bad_dllp,
  // Non-fatal sources, then own transmit error that masks all classes
  input  wire logic                   poisoned_tlp,
  input  wire logic                   ecrc_fail,
  input  wire logic                   completer_abort,
  input  wire logic                   unexpected_cpl,
  input  wire logic                   acs_violation,
  input  wire logic                   tx_side_err,
  // Request address check
  input  wire logic                   rx_req_valid,
  input  wire logic [31:0]            rx_req_addr,
  input  wire logic [NUM_BARS*32-1:0] bar_base,
  input  wire logic [NUM_BARS*32-1:0] bar_mask,
  // Transmit tracking
  input  wire logic                   tx_tlp_sent,
  input  wire logic                   ack_rcvd,
  input  wire logic                   req_sent,
  input  wire logic                   cpl_rcvd,
  // Control
  input  wire logic                   report_en,
  input  wire logic [STAT_W-1:0]      stat_clear,
  // Results
  output logic                        replay_req,
  output logic                        msg_valid,
  output pec_msg_t                    msg_type,
  output logic [STAT_W-1:0]           dev_status
);
  logic              replay_to;
  logic              cpl_to;
  logic [7:0]        roll_cnt;
  logic              roll_err;
  logic              ur_hit;
  logic              ev_fatal;
  logic              ev_corr;
  logic              ev_nf;
  logic [STAT_W-1:0] set_bits;

  function automatic logic bar_match(input logic [31:0] a,
                                     input logic [NUM_BARS*32-1:0] b,
                                     input logic [NUM_BARS*32-1:0] m);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_BARS; i++) begin
      if ((a & m[i*32 +: 32]) == (b[i*32 +: 32] & m[i*32 +: 32])) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Replay timer
  pec_timer #(.LIMIT(REPLAY_LIMIT)) u_replay (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (tx_tlp_sent),
    .stop    (ack_rcvd),
    .expired (replay_to)
  );

  // Completion timer
  pec_timer #(.LIMIT(CPL_LIMIT)) u_cpl (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (req_sent),
    .stop    (cpl_rcvd),
    .expired (cpl_to)
  );

  // Replay on timeout
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      replay_req <= 1'b0;
    end else begin
      replay_req <= replay_to;
    end
  end

  // Replay rollover counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      roll_cnt <= 8'h00;
      roll_err <= 1'b0;
    end else begin
      roll_err <= 1'b0;
      if (ack_rcvd) begin
        roll_cnt <= 8'h00;
      end else if (replay_to && roll_cnt == 8'(ROLL_MAX - 1)) begin
        roll_cnt <= 8'h00;
        roll_err <= 1'b1;
      end else if (replay_to) begin
        roll_cnt <= roll_cnt + 8'h01;
      end
    end
  end

  // Event classes
  assign ur_hit   = rx_req_valid && !bar_match(rx_req_addr, bar_base, bar_mask);
  assign ev_fatal = training_err | dll_proto_err | fc_proto_err
                  | malformed_tlp | rx_overflow;
  assign ev_corr  = receiver_err | bad_tlp | bad_dllp | replay_to | roll_err;
  assign ev_nf    = (poisoned_tlp | ecrc_fail | completer_abort | unexpected_cpl
                  | acs_violation | cpl_to | ur_hit) && !tx_side_err;

  // Status bits raised this cycle
  always_comb begin
    set_bits = STAT_RESET;
    set_bits[STAT_FAT_BIT]  = ev_fatal && !tx_side_err;
    set_bits[STAT_CORR_BIT] = ev_corr && !tx_side_err;
    set_bits[STAT_NF_BIT]   = ev_nf;
    set_bits[STAT_UR_BIT]   = ur_hit && !tx_side_err;
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dev_status <= STAT_RESET;
    end else begin
      dev_status <= (dev_status & ~stat_clear) | set_bits;
    end
  end

  // Upstream messages, most severe first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msg_valid <= 1'b0;
      msg_type  <= PEC_MSG_COR;
    end else begin
      msg_valid <= report_en && (set_bits[STAT_FAT_BIT] || set_bits[STAT_NF_BIT]
                   || set_bits[STAT_CORR_BIT]);
      if (set_bits[STAT_FAT_BIT]) begin
        msg_type <= PEC_MSG_FATAL;
      end else if (set_bits[STAT_NF_BIT]) begin
        msg_type <= PEC_MSG_NONFATAL;
      end else begin
        msg_type <= PEC_MSG_COR;
      end
    end
  end

  sequence s_fatal_seen;
    ev_fatal && !tx_side_err;
  endsequence

  sequence s_replay_fire;
    replay_to && !ack_rcvd;
  endsequence

  sequence s_roll_full;
    roll_cnt == 8'(ROLL_MAX - 1);
  endsequence

  sequence s_restart;
    tx_tlp_sent || ack_rcvd;
  endsequence

  // Classification, status and messages
  a_fatal_status: assert property (@(posedge clock) disable iff (!rst_n)
    s_fatal_seen |=> dev_status[STAT_FAT_BIT]) else $error("fatal not flagged");
  a_fatal_msg: assert property (@(posedge clock) disable iff (!rst_n)
    s_fatal_seen and report_en |=> msg_valid && msg_type == PEC_MSG_FATAL)
    else $error("fatal message missing");
  a_no_report: assert property (@(posedge clock) disable iff (!rst_n)
    !report_en |=> !msg_valid) else $error("message while disabled");
  a_corr_class: assert property (@(posedge clock) disable iff (!rst_n)
    (bad_dllp || receiver_err || bad_tlp) && !tx_side_err |=> dev_status[STAT_CORR_BIT])
    else $error("correctable not flagged");
  a_corr_msg: assert property (@(posedge clock) disable iff (!rst_n)
    ev_corr && !tx_side_err && !ev_fatal && !ev_nf && report_en
    |=> msg_valid && msg_type == PEC_MSG_COR) else $error("correctable message wrong");
  a_nf_class: assert property (@(posedge clock) disable iff (!rst_n)
    (poisoned_tlp || ecrc_fail || acs_violation) && !tx_side_err |=> dev_status[STAT_NF_BIT])
    else $error("non-fatal not flagged");
  a_nf_msg: assert property (@(posedge clock) disable iff (!rst_n)
    ev_nf && !ev_fatal && report_en |=> msg_valid && msg_type == PEC_MSG_NONFATAL)
    else $error("non-fatal message wrong");
  a_ur_bar: assert property (@(posedge clock) disable iff (!rst_n)
    ur_hit && !tx_side_err |=> dev_status[STAT_UR_BIT] && dev_status[STAT_NF_BIT])
    else $error("UR not flagged");
  a_cpl_timeout: assert property (@(posedge clock) disable iff (!rst_n)
    cpl_to && !tx_side_err |=> dev_status[STAT_NF_BIT]) else $error("cpl timeout lost");
  a_tx_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    tx_side_err && dev_status == STAT_RESET |=> dev_status == STAT_RESET)
    else $error("own tx error recorded");
  a_tx_no_msg: assert property (@(posedge clock) disable iff (!rst_n)
    tx_side_err |=> !msg_valid) else $error("message for own tx error");
  a_sticky_hold: assert property (@(posedge clock) disable iff (!rst_n)
    dev_status[STAT_FAT_BIT] && !stat_clear[STAT_FAT_BIT] |=> dev_status[STAT_FAT_BIT])
    else $error("status dropped");
  a_clear_works: assert property (@(posedge clock) disable iff (!rst_n)
    stat_clear[STAT_FAT_BIT] && (!ev_fatal || tx_side_err) |=> !dev_status[STAT_FAT_BIT])
    else $error("status not cleared");

  // Replay timing and rollover
  a_replay_out: assert property (@(posedge clock) disable iff (!rst_n)
    replay_to |=> replay_req && (dev_status[STAT_CORR_BIT] || $past(tx_side_err)))
    else $error("no replay");
  a_replay_stop: assert property (@(posedge clock) disable iff (!rst_n)
    s_restart |=> !replay_to) else $error("replay after ack or restart");
  a_roll_err: assert property (@(posedge clock) disable iff (!rst_n)
    s_replay_fire and s_roll_full |=> roll_err && roll_cnt == 8'h00)
    else $error("rollover not signalled");
  a_roll_corr: assert property (@(posedge clock) disable iff (!rst_n)
    roll_err && !tx_side_err |=> dev_status[STAT_CORR_BIT]) else $error("rollover not flagged");
endmodule // pec_classifier

// ### src/pec_pkg.sv
// What this block does
// - Error messages go upstream only when reporting enabled
// - Training, DLL, FC, malformed, overflow are fatal
// - Receiver, bad TLP/DLLP, replay errors are correctable
// - Poison, ECRC, UR, completion timeouts, aborts, ACS are non-fatal
// - Receive detects link errors; transmit flags replay errors
// - Replay a packet unacknowledged within replay time
// - Request outside every BAR is an unsupported request
// - Requester reports completion timeout for missing completions
// - Own transmit traffic errors never set device status
// - Fatal error shows in device status bit 2
package pec_pkg;
  localparam int FATAL_SRC_W   = 5;
  localparam int CORR_SRC_W    = 3;
  localparam int NF_SRC_W      = 6;
  localparam int STAT_W        = 4;
  localparam int STAT_CORR_BIT = 0;
  localparam int STAT_NF_BIT   = 1;
  localparam int STAT_FAT_BIT  = 2;
  localparam int STAT_UR_BIT   = 3;
  localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 5;
  localparam int REPLAY_TIME_NS = 4000;
  localparam int REPLAY_CYCLES = REPLAY_TIME_NS / CLK_PERIOD_NS;
  localparam int CPL_TIME_NS   = 50000;
  localparam int CPL_CYCLES    = CPL_TIME_NS / CLK_PERIOD_NS;
  localparam int ROLLOVER_MAX  = 4;
  localparam int NUM_BARS      = 2;

  typedef enum logic [1:0] {
    PEC_MSG_COR,
    PEC_MSG_NONFATAL,
    PEC_MSG_FATAL
  } pec_msg_t;
endpackage

// ### src/pec_timer.sv
`timescale 1ns/100ps
module pec_timer import pec_pkg::*; #(
  parameter int LIMIT = 16
) (
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic stop,
  // Result
  output logic      expired
);
  localparam int CW = $clog2(LIMIT + 1);
  logic [CW-1:0] count;
  logic          run;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run   <= 1'b0;
      count <= '0;
    end else if (stop) begin
      run   <= 1'b0;
      count <= '0;
    end else if (start) begin
      run   <= 1'b1;
      count <= '0;
    end else if (run && count == CW'(LIMIT - 1)) begin
      run   <= 1'b0;
      count <= '0;
    end else if (run) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= run && !stop && !start && count == CW'(LIMIT - 1);
    end
  end
endmodule // pec_timer

// ### verification/pec_link_partner.sv
`timescale 1ns/100ps
module pec_link_partner import pec_pkg::*; (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Behaviour select
  input  wire logic ack_on,
  input  wire logic cpl_on,
  // Traffic from the endpoint
  input  wire logic tx_tlp_sent,
  input  wire logic req_sent,
  // Answers
  output logic      ack_rcvd,
  output logic      cpl_rcvd
);
  logic [2:0] ack_pipe;
  logic [1:0] cpl_pipe;
  // Acknowledge three cycles after each packet, only when allowed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ack_pipe <= 3'h0;
    else ack_pipe <= {ack_pipe[1:0], tx_tlp_sent & ack_on};
  end
  // Completion two cycles after each request, only when allowed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cpl_pipe <= 2'h0;
    else cpl_pipe <= {cpl_pipe[0], req_sent & cpl_on};
  end
  assign ack_rcvd = ack_pipe[2];
  assign cpl_rcvd = cpl_pipe[1];
endmodule // pec_link_partner

// ### verification/test_pcie_error_classifier.sv
`timescale 1ns/100ps
module test_pcie_error_classifier import pec_pkg::*; ;
  logic        clock, rst_n, txe, rqv, tts, rqs, ren, ack_on, cpl_on;
  logic        rr, mv, ack, cpl, seen;
  logic [4:0]  fat, nf;
  logic [2:0]  cor;
  logic [3:0]  clr, ds;
  logic [31:0] addr;
  pec_msg_t    mt;
  int          errors, checks_done;
  pec_classifier #(.REPLAY_LIMIT(8), .CPL_LIMIT(20)) i_pec_classifier (
    .clock(clock), .rst_n(rst_n), .training_err(fat[0]), .dll_proto_err(fat[1]),
    .fc_proto_err(fat[2]), .malformed_tlp(fat[3]), .rx_overflow(fat[4]),
    .receiver_err(cor[0]), .bad_tlp(cor[1]), .bad_dllp(cor[2]), .poisoned_tlp(nf[0]),
    .ecrc_fail(nf[1]), .completer_abort(nf[2]), .unexpected_cpl(nf[3]),
    .acs_violation(nf[4]), .tx_side_err(txe), .rx_req_valid(rqv), .rx_req_addr(addr),
    .bar_base(64'h2000_0000_1000_0000), .bar_mask(64'hffff_f000_ffff_f000),
    .tx_tlp_sent(tts), .ack_rcvd(ack), .req_sent(rqs), .cpl_rcvd(cpl), .report_en(ren),
    .stat_clear(clr), .replay_req(rr), .msg_valid(mv), .msg_type(mt), .dev_status(ds));
  pec_link_partner i_pec_link_partner (.clock(clock), .rst_n(rst_n), .ack_on(ack_on),
    .cpl_on(cpl_on), .tx_tlp_sent(tts), .req_sent(rqs), .ack_rcvd(ack), .cpl_rcvd(cpl));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task step;
    @(posedge clock);
    #1;
  endtask
  task ev(input logic [4:0] f, input logic [2:0] c, input logic [4:0] n, input logic t);
    @(posedge clock);
    fat <= f; cor <= c; nf <= n; txe <= t;
    @(posedge clock);
    fat <= 0; cor <= 0; nf <= 0; txe <= 0;
    #1;
  endtask
  task clear_all;
    @(posedge clock);
    clr <= 4'hf;
    @(posedge clock);
    clr <= 4'h0;
    #1;
    chk("clear", ds, 8'h0);
  endtask
  task t_classes;
    for (int i = 0; i < 5; i++) begin
      ev(5'(1 << i), 0, 0, 0);
      chk("fat_msg", mv, 8'h1);
      chk("fat_type", mt, PEC_MSG_FATAL);
      chk("fat_bit", ds[2], 8'h1);
      step();
      chk("msg_pulse", mv, 8'h0);
      repeat (4) step();
      chk("fat_hold", ds[2], 8'h1);
      clear_all();
    end
    for (int i = 0; i < 3; i++) begin
      ev(0, 3'(1 << i), 0, 0);
      chk("cor_type", mt, PEC_MSG_COR);
      chk("cor_bit", ds[0], 8'h1);
      clear_all();
    end
    for (int i = 0; i < 5; i++) begin
      ev(0, 0, 5'(1 << i), 0);
      chk("nf_type", mt, PEC_MSG_NONFATAL);
      chk("nf_bit", ds[1], 8'h1);
      clear_all();
    end
    ev(5'h1, 3'h1, 0, 0);
    chk("sev_type", mt, PEC_MSG_FATAL);
    clear_all();
  endtask
  task t_quiet;
    @(posedge clock);
    ren <= 0;
    ev(5'h8, 0, 0, 0);
    chk("off_msg", mv, 8'h0);
    chk("off_bit", ds[2], 8'h1);
    clear_all();
    @(posedge clock);
    ren <= 1;
    ev(5'h1f, 3'h7, 5'h1f, 1);
    chk("own_tx", ds, 8'h0);
    chk("own_msg", mv, 8'h0);
  endtask
  task req(input logic [31:0] a);
    @(posedge clock);
    addr <= a; rqv <= 1;
    @(posedge clock);
    rqv <= 0;
    #1;
  endtask
  task t_ur;
    req(32'h1000_0010);
    chk("bar_hit", ds, 8'h0);
    req(32'h2000_0ff0);
    chk("bar1_hit", ds, 8'h0);
    req(32'h3000_0000);
    chk("ur_bit", ds[3], 8'h1);
    chk("ur_type", mt, PEC_MSG_NONFATAL);
    clear_all();
  endtask
  task pulse_tx(input logic r);
    @(posedge clock);
    if (r) rqs <= 1; else tts <= 1;
    @(posedge clock);
    rqs <= 0; tts <= 0;
    #1;
  endtask
  task t_timers;
    pulse_tx(0);
    repeat (8) step();
    chk("replay_early", rr, 8'h0);
    step();
    chk("replay", rr, 8'h1);
    chk("replay_cor", ds[0], 8'h1);
    chk("replay_msg", mv, 8'h1);
    chk("replay_type", mt, PEC_MSG_COR);
    clear_all();
    ack_on <= 1;
    pulse_tx(0);
    seen = 0;
    repeat (12) begin step(); seen |= rr; end
    chk("acked", seen, 8'h0);
    pulse_tx(1);
    seen = 0;
    repeat (30) begin step(); seen |= ds[1]; end
    chk("cpl_ok", seen, 8'h0);
    cpl_on <= 0;
    pulse_tx(1);
    for (int i = 0; i < 30 && ds[1] !== 1'b1; i++) step();
    chk("cpl_tmo", ds[1], 8'h1);
  endtask
  task t_roll;
    ack_on <= 0;
    clear_all();
    for (int i = 0; i < 4; i++) begin
      pulse_tx(0);
      repeat (8) step();
      @(posedge clock);
      clr <= 4'hf;
      @(posedge clock);
      clr <= 4'h0;
      #1;
      chk("rollover", ds[0], 8'(i == 3));
    end
    clear_all();
  endtask
  task stop_test;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst_n = 0; fat = 0; cor = 0; nf = 0; txe = 0; rqv = 0; addr = 0; tts = 0;
    rqs = 0; ren = 1; clr = 0; ack_on = 0; cpl_on = 1; errors = 0; checks_done = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1;
    step();
    t_classes();
    t_quiet();
    t_ur();
    t_timers();
    t_roll();
    stop_test();
  end
endmodule // test_pcie_error_classifier
